// ---- bench/tank_sim.sv ----
`timescale 1ns/1ps
`default_nettype none
module tank_sim (
  input  wire logic [3:0] fill,         // wet probes from the bottom
  input  wire logic [3:0] stuck,        // failed dry probe, 0 none
  output logic      [9:0] probe_wet_in  // probes, bit0 bottom
);
  // probes under the fill line read wet, a failed one reads dry
  always_comb
  begin
    for (int i = 0; i < 10; i++)
      probe_wet_in[i] = (i < fill) && (i + 1 != stuck);
  end
endmodule
`default_nettype wire

// ---- bench/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bready = 0, arv = 0;
  logic rready = 0, alm = 0, zero = 0, mute = 0;
  logic [11:0] awaddr = 0, araddr = 0, ain = 0;
  logic [31:0] wdata = 0, rd;
  logic [3:0] fill = 0, stuck = 0, lanes = 4'hf;
  logic [1:0] r, bresp, rresp;
  logic [9:0] wet, seg;
  logic [5:0] relay;
  logic [31:0] rdata;
  logic awr, wrdy, bv, arr, rv, oc, oe, flt;
  int fail_count = 0, n_compared = 0;
  always #12.5 aclk = ~aclk;  // 40 MHz
  tank_sim i_tank_sim (.fill(fill), .stuck(stuck), .probe_wet_in(wet));
  tank_level_relay_controller #(.TICK_CYCLES(10))
    i_tank_level_relay_controller (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wdata), .s_axi_wstrb(lanes), .s_axi_wvalid(wv),
    .s_axi_wready(wrdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rv), .s_axi_rready(rready), .probe_wet_in(wet),
    .analog_in(ain), .crit_alarm(alm), .noncrit_alarm(zero),
    .local_alarm(alm), .power_fault(zero), .mute_req(mute),
    .segment_out(seg), .relay_out(relay), .oc_out(oc), .oc_oe(oe),
    .probe_fault(flt));
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic close_out;
    $display("compared %0d errors %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] e, g);
    n_compared++;
    if (g !== e)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic guard(input int n);  // a hung handshake ends the run
    if (n == 40)
    begin
      fail_count++;
      close_out();
    end
  endtask
  task automatic axw(input logic [11:0] a, input logic [31:0] d);
    int n;
    awaddr <= a; wdata <= d; awv <= 1; wv <= 1; bready <= 1;
    for (n = 0; n < 40 && !bv; n++)
    begin
      @(posedge aclk);
      if (awr) awv <= 0;  // each half released once taken
      if (wrdy) wv <= 0;
    end
    r = bresp;
    bready <= 0;
    guard(n);
    @(posedge aclk);  // ready stays low for one edge between writes
  endtask
  task automatic axr(input logic [11:0] a);
    int n;
    araddr <= a; arv <= 1; rready <= 1;
    for (n = 0; n < 40 && !rv; n++)
    begin
      @(posedge aclk);
      if (arr) arv <= 0;
    end
    rd = rdata;
    r = rresp;
    rready <= 0;
    guard(n);
    @(posedge aclk);  // ready stays low for one edge between reads
  endtask
  task automatic settle;  // sync, level and channel stages
    repeat (8) @(posedge aclk);
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_probes;
    axr(12'h004);
    chk("status", 32'h0, rd);
    fill <= 4'h3;
    settle();
    chk("segments", 32'h7, {22'h0, seg});
    axr(12'h004);
    chk("level", 32'h3, {28'h0, rd[3:0]});
    axw(12'h000, 32'h4);  // gap alarm on
    fill <= 4'h5;
    stuck <= 4'h2;
    settle();
    chk("fault", 32'h1, {31'h0, flt});
    chk("segments", 32'h1d, {22'h0, seg});
    axr(12'h004);
    chk("level", 32'h5, {28'h0, rd[3:0]});
    stuck <= 4'h0;
  endtask
  task automatic t_relays;
    axw(12'h108, 32'h3c);  // normal mode 30/60, second setpoint first
    axw(12'h104, 32'h1e);
    settle();
    chk("ch0 idle", 32'h0, {31'h0, relay[0]});
    fill <= 4'h7;
    settle();
    chk("ch0 on", 32'h1, {31'h0, relay[0]});
    fill <= 4'h3;
    settle();
    chk("ch0 off", 32'h0, {31'h0, relay[0]});
    axw(12'h120, 32'h2);  // ch1 critical
    axw(12'h124, 32'h5);
    alm <= 1;
    settle();
    chk("ch1 alarm", 32'h1, {31'h0, relay[1]});
    axr(12'h114);  // sixth parameter slot
    chk("resp", 32'h2, {30'h0, r});
  endtask
  task automatic t_alarms;  // alarm still raised from t_relays
    axw(12'h140, 32'h4);  // ch2 noncritical
    axw(12'h144, 32'h5);
    axw(12'h1a0, 32'h8);  // ch5 buzzer
    axw(12'h1a4, 32'h5);
    settle();
    chk("ch2 local", 32'h1, {31'h0, relay[2]});
    chk("buzzer on", 32'h1, {31'h0, oe});
    chk("oc level", 32'h0, {31'h0, oc});
    mute <= 1;
    @(posedge aclk);
    mute <= 0;
    settle();
    chk("muted", 32'h0, {31'h0, oe});
    chk("ch1 held", 32'h1, {31'h0, relay[1]});
    alm <= 0;
    settle();
    chk("ch1 off", 32'h0, {31'h0, relay[1]});
    alm <= 1;
    settle();
    chk("rearmed", 32'h1, {31'h0, oe});
  endtask
  task automatic t_analog;  // half input, 1500 mm scale, 2000 mm tank
    ain <= 12'h800;
    axw(12'h000, 32'h1);
    settle();
    chk("bar", 32'hf, {22'h0, seg});
    axr(12'h004);
    chk("analog level", 32'h4, {28'h0, rd[3:0]});
  endtask
  initial
  begin
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    t_probes();
    t_relays();
    t_alarms();
    t_analog();
    close_out();
  end
endmodule
`default_nettype wire

// ---- design/relay_channel.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "tank_consts.svh"
module relay_channel (
  input  wire logic          aclk,       // system clock
  input  wire logic          aresetn,    // sync reset, low
  input  wire logic          sec_tick,   // one-second pulse
  input  wire logic [15:0]   cfg_bits,   // start state, function
  input  wire logic [15:0]   sp1,        // first trip percent, upper when above sp2
  input  wire logic [15:0]   sp2,        // second trip percent, lower when below sp1
  input  wire logic [15:0]   dly1,       // turn_on_delay seconds, turn-off for level with sp1 < sp2
  input  wire logic [15:0]   dly2,       // turn_off_delay seconds, turn-on for level with sp1 < sp2
  input  wire logic [6:0]    level_pct,  // level as percent
  input  wire logic [4:0]    src_vec,    // alarm sources by code
  output logic               relay_out   // channel drive
);
  // ----------------------------------------------------------
  // condition decode
  // ----------------------------------------------------------
  logic [15:0]         lvl;       // level widened
  logic                set_c;     // leave start state
  logic                clr_c;     // return to start state
  logic [15:0]         dly_on;    // delay toward active
  logic [15:0]         dly_off;   // delay toward idle
  logic                active;    // away from start state
  logic [`DELAY_W-1:0] timer;     // seconds elapsed
  logic                pending;   // condition awaiting delay
  logic [`DELAY_W-1:0] need;      // delay now in force
  logic                disabled;  // held off

  assign lvl      = {9'h000, level_pct};
  assign disabled = (sp1 == 16'h0000);
  // settle on conditions from function and setpoints
  always_comb
  begin
    set_c   = 1'b0;
    clr_c   = 1'b0;
    dly_on  = dly1;
    dly_off = dly2;
    case (tank_pkg::func_e'(cfg_bits[3:1]))
      tank_pkg::FN_LEVEL:
      begin
        if (sp1 > sp2)
        begin
          set_c = (lvl >= sp1);
          clr_c = (lvl <= sp2);
        end
        else if (sp1 < sp2)
        begin
          set_c   = (lvl >= sp2);
          clr_c   = (lvl <= sp1);
          dly_on  = dly2;
          dly_off = dly1;
        end
        else
        begin
          set_c = (lvl > sp1);
          clr_c = (lvl < sp1);
        end
      end
      tank_pkg::FN_CRIT,
      tank_pkg::FN_NONCRIT,
      tank_pkg::FN_POWER,
      tank_pkg::FN_BUZZER:
      begin
        set_c = src_vec[cfg_bits[3:1]];
        clr_c = !src_vec[cfg_bits[3:1]];
      end
      default:
      begin
        clr_c = 1'b1;                                   // unknown: idle
      end
    endcase
  end

  assign pending = active ? clr_c : set_c;
  assign need    = active ? dly_off[`DELAY_W-1:0] : dly_on[`DELAY_W-1:0];

  // ----------------------------------------------------------
  // delay timer, cleared when no crossing is pending
  // ----------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !pending)
      timer <= '0;
    else if (sec_tick && (timer < need))
      timer <= timer + 1'b1;
  end

  // switch state once the delay is met; zero delay is immediate
  always_ff @(posedge aclk)
  begin
    if (!aresetn || disabled)
      active <= 1'b0;
    else if (pending && (timer >= need))
      active <= !active;
  end

  // output drive from the start-state bit
  always_ff @(posedge aclk)
  begin
    if (!aresetn || disabled)
      relay_out <= 1'b0;
    else
      relay_out <= cfg_bits[0] ^ active;
  end

  // ----------------------------------------------------------
  // checks
  // ----------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_zero_sp_off: assert property (disabled |=> !relay_out)
    else $error("channel with zero setpoint is driven");
  chk_nodelay_flip: assert property (
    (pending && need == '0 && !disabled) |=> (active != $past(active)))
    else $error("zero delay did not switch at once");
  chk_idle_timer: assert property (!pending |=> timer == '0)
    else $error("timer not cleared between setpoints");
  chk_out_follows: assert property (
    !disabled
    |=> relay_out == ($past(cfg_bits[0]) ^ $past(active)))
    else $error("output disagrees with start state");
  cov_switch: cover property (!active ##1 active);
endmodule
`default_nettype wire

// ---- design/tank_consts.svh ----
`ifndef TANK_CONSTS_SVH
`define TANK_CONSTS_SVH
// sizes
`define N_PROBES       10
`define N_CHANS        7
`define N_PARAMS       5
`define AIN_W          12
`define DELAY_W        12
`define LEVEL_MAX      4'ha
`define PCT_PER_STEP   7'h0a
// timing
`define CLK_PERIOD_NS  25
`define SECOND_NS      1000000000
`define SEC_CYCLES     (`SECOND_NS / `CLK_PERIOD_NS)
// register byte offsets
`define OFS_CONTROL    12'h000
`define OFS_STATUS     12'h004
`define OFS_SCALE      12'h008
`define OFS_OFFSET     12'h00c
`define OFS_MAXDEPTH   12'h010
`define CHAN_SEL_BIT   8
// control register fields
`define CTL_ANALOG_BIT 0
`define CTL_HIGHEN_BIT 1
`define CTL_FAULTEN_BIT 2
`define CTL_HIDX_LSB   4
// reset values
`define SCALE_RESET    16'h05dc
`define OFFSET_RESET   16'h0000
`define MAXD_RESET     16'h07d0
// bus responses
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2
`endif

// ---- design/tank_level_relay_controller.sv ----
// Notes on behaviour
// - ten probe inputs, input one lowest
// - analogue depth is input times scale plus offset
// - ten-segment bar shows tank level
// - multipoint segment lit when its probe wet
// - level is highest wet probe with wet below
// - wet high probe forces level at least high
// - optional alarm on probe gap, level continues
// - analogue bar adds segment per ten percent
// - six relays plus one open-collector output
// - five parameters per channel, bit0 start state
// - bits one to three choose channel function
// - setpoints are percent, zero first disables
// - delays in seconds, zero means none
// - level scale runs eleven steps, zero to ten
// - first above second gives hysteresis with delays
// - timers cleared while level between setpoints
// - equal setpoints switch above and below
// - alarm functions use on and off delays
// - critical, noncritical and local alarm routing
// - mute silences buzzer until a new alarm
//
// Added by the designer: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "tank_consts.svh"
module tank_level_relay_controller #(
  parameter int unsigned TICK_CYCLES = `SEC_CYCLES  // cycles per second
) (
  input  wire logic              aclk,           // 40 MHz clock
  input  wire logic              aresetn,        // sync reset, low
  input  wire logic [11:0]       s_axi_awaddr,   // write address
  input  wire logic              s_axi_awvalid,  // write address valid
  output logic                   s_axi_awready,  // write address ready
  input  wire logic [31:0]       s_axi_wdata,    // write data
  input  wire logic [3:0]        s_axi_wstrb,    // write byte lanes
  input  wire logic              s_axi_wvalid,   // write data valid
  output logic                   s_axi_wready,   // write data ready
  output logic [1:0]             s_axi_bresp,    // write response
  output logic                   s_axi_bvalid,   // write response valid
  input  wire logic              s_axi_bready,   // write response ready
  input  wire logic [11:0]       s_axi_araddr,   // read address
  input  wire logic              s_axi_arvalid,  // read address valid
  output logic                   s_axi_arready,  // read address ready
  output logic [31:0]            s_axi_rdata,    // read data
  output logic [1:0]             s_axi_rresp,    // read response
  output logic                   s_axi_rvalid,   // read data valid
  input  wire logic              s_axi_rready,   // read data ready
  input  wire logic [9:0]        probe_wet_in,   // probes, bit0 bottom
  input  wire logic [11:0]       analog_in,      // normalised depth
  input  wire logic              crit_alarm,     // critical alarm level
  input  wire logic              noncrit_alarm,  // noncritical alarm
  input  wire logic              local_alarm,    // local alarm level
  input  wire logic              power_fault,    // phase loss level
  input  wire logic              mute_req,       // mute pulse
  output logic [9:0]             segment_out,    // bar display
  output logic [5:0]             relay_out,      // relay coils
  output logic                   oc_out,         // open collector level
  output logic                   oc_oe,          // open collector sink
  output logic                   probe_fault     // probe gap alarm
);
  // ----------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------
  logic [9:0]  probe_m;    // probe first stage
  logic [9:0]  probe_s;    // probe synced
  logic [11:0] ain_m;      // analogue first stage
  logic [11:0] ain_s;      // analogue synced
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      probe_m <= '0;
      probe_s <= '0;
      ain_m   <= '0;
      ain_s   <= '0;
    end
    else
    begin
      probe_m <= probe_wet_in;
      probe_s <= probe_m;
      ain_m   <= analog_in;
      ain_s   <= ain_m;
    end
  end

  // ----------------------------------------------------------
  // registers
  // ----------------------------------------------------------
  logic [15:0] ctl_reg;                   // mode and high select
  logic [15:0] scale_reg;                 // full-scale depth mm
  logic [15:0] offs_reg;                  // depth offset mm
  logic [15:0] maxd_reg;                  // tank maximum depth mm
  tank_pkg::param_t chan_reg [0:34];      // channel parameters
  logic [3:0]  level_reg;                 // level step 0..10
  logic [9:0]  seg_reg;                   // segment drive
  logic        fault_reg;                 // probe gap flag
  logic [6:0]  chan_q;                    // channel drives
  logic        analog_mode;               // analogue level source
  assign analog_mode = ctl_reg[`CTL_ANALOG_BIT];

  // address decode: returns index 0..34 or flags miss
  function automatic logic [5:0] chan_idx(input logic [11:0] a);
    logic [5:0] c;
    c = {3'h0, a[7:5]};
    chan_idx = 6'((c << 2) + c + {3'h0, a[4:2]});
  endfunction
  function automatic logic chan_hit(input logic [11:0] a);
    chan_hit = a[`CHAN_SEL_BIT] && (a[11:9] == 3'h0)
               && (a[7:5] < 3'h7) && (a[4:2] < 3'h5);
  endfunction
  function automatic logic glob_hit(input logic [11:0] a);
    glob_hit = (a[11:5] == 7'h00) && (a[4:2] < 3'h5);
  endfunction
  // byte-lane merge on a 16-bit register
  function automatic logic [15:0] merge(input logic [15:0] o,
                                        input logic [31:0] d,
                                        input logic [3:0]  s);
    merge = {s[1] ? d[15:8] : o[15:8], s[0] ? d[7:0] : o[7:0]};
  endfunction

  // ----------------------------------------------------------
  // write channel
  // ----------------------------------------------------------
  logic        aw_hold;    // address captured
  logic [11:0] aw_addr;    // captured address
  logic        w_hold;     // data captured
  logic [31:0] w_data;     // captured data
  logic [3:0]  w_strb;     // captured lanes
  logic        do_write;   // both halves present
  assign s_axi_awready = !aw_hold && !s_axi_bvalid;
  assign s_axi_wready  = !w_hold && !s_axi_bvalid;
  assign do_write      = aw_hold && w_hold && !s_axi_bvalid;

  // capture address and data in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold <= 1'b0;
      aw_addr <= '0;
      w_hold  <= 1'b0;
      w_data  <= '0;
      w_strb  <= '0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      else if (do_write)
        aw_hold <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      else if (do_write)
        w_hold <= 1'b0;
    end
  end

  // write response, held until taken
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (chan_hit(aw_addr) || glob_hit(aw_addr))
                      ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // global register stores
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctl_reg   <= 16'h0000;
      scale_reg <= `SCALE_RESET;
      offs_reg  <= `OFFSET_RESET;
      maxd_reg  <= `MAXD_RESET;
    end
    else if (do_write && glob_hit(aw_addr))
    begin
      case ({aw_addr[11:2], 2'h0})
        `OFS_CONTROL:  ctl_reg   <= merge(ctl_reg, w_data, w_strb);
        `OFS_SCALE:    scale_reg <= merge(scale_reg, w_data, w_strb);
        `OFS_OFFSET:   offs_reg  <= merge(offs_reg, w_data, w_strb);
        `OFS_MAXDEPTH: maxd_reg  <= merge(maxd_reg, w_data, w_strb);
        default:       ;                                // status is read-only
      endcase
    end
  end

  // channel parameter stores
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int i = 0; i < 35; i++)
        chan_reg[i] <= 16'h0000;
    end
    else if (do_write && chan_hit(aw_addr))
      chan_reg[chan_idx(aw_addr)] <=
        merge(chan_reg[chan_idx(aw_addr)], w_data, w_strb);
  end

  // ----------------------------------------------------------
  // read channel
  // ----------------------------------------------------------
  logic [31:0] rd_mux;   // selected read word
  assign s_axi_arready = !s_axi_rvalid;
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (chan_hit(s_axi_araddr))
      rd_mux = {16'h0000, chan_reg[chan_idx(s_axi_araddr)]};
    else
      case ({s_axi_araddr[11:2], 2'h0})
        `OFS_CONTROL:  rd_mux = {16'h0000, ctl_reg};
        `OFS_STATUS:   rd_mux = {6'h00, seg_reg, 1'b0, chan_q,
                                 3'h0, fault_reg, level_reg};
        `OFS_SCALE:    rd_mux = {16'h0000, scale_reg};
        `OFS_OFFSET:   rd_mux = {16'h0000, offs_reg};
        `OFS_MAXDEPTH: rd_mux = {16'h0000, maxd_reg};
        default:       rd_mux = 32'h0000_0000;
      endcase
  end

  // read data register, held until taken
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= `RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_mux;
      s_axi_rresp  <= (chan_hit(s_axi_araddr) || glob_hit(s_axi_araddr))
                      ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // ----------------------------------------------------------
  // level derivation
  // ----------------------------------------------------------
  logic [27:0] ain_prod;    // input times scale
  logic [16:0] depth_mm;    // depth from tank bottom
  logic [9:0]  thermo;      // analogue bar pattern
  logic [3:0]  lvl_multi;   // multipoint level step
  logic [3:0]  lvl_ana;     // analogue level step
  logic        gap;         // wet probe above dry probe
  logic [3:0]  hidx;        // high level probe index
  assign hidx     = ctl_reg[`CTL_HIDX_LSB +: 4];
  assign ain_prod = ain_s * scale_reg;
  assign depth_mm = {1'b0, ain_prod[27:12]} + {1'b0, offs_reg};
  assign gap      = |(probe_s[9:1] & ~probe_s[8:0]);

  // one segment per band: depth*20 >= maxd*(2k-1)
  for (genvar k = 1; k <= 10; k++)
  begin : g_band
    assign thermo[k-1] = ({6'h00, depth_mm} * 23'd20)
                         >= ({7'h00, maxd_reg} * 23'(2 * k - 1));
  end

  // highest wet probe with wet below, with high level override
  always_comb
  begin
    logic below;
    below     = 1'b0;
    lvl_multi = 4'h0;
    lvl_ana   = 4'h0;
    for (int i = 0; i < `N_PROBES; i++)
    begin
      if (probe_s[i] && (i == 0 || probe_s[(i == 0) ? 0 : i - 1]))
        lvl_multi = 4'(i + 1);
      if (thermo[i])
        lvl_ana = 4'(i + 1);
    end
    for (int j = 0; j < `N_PROBES; j++)
      if (4'(j) < hidx && probe_s[j])
        below = 1'b1;
    if (ctl_reg[`CTL_HIGHEN_BIT] && hidx < `LEVEL_MAX
        && probe_s[hidx] && below && lvl_multi <= hidx)
      lvl_multi = hidx + 4'h1;
  end

  // registered level, display and gap flag
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      level_reg <= 4'h0;
      seg_reg   <= '0;
      fault_reg <= 1'b0;
    end
    else
    begin
      level_reg <= analog_mode ? lvl_ana : lvl_multi;
      seg_reg   <= analog_mode ? thermo : probe_s;
      fault_reg <= ctl_reg[`CTL_FAULTEN_BIT] && !analog_mode
                   && gap;
    end
  end
  assign segment_out = seg_reg;
  assign probe_fault = fault_reg;

  // ----------------------------------------------------------
  // alarm routing and mute
  // ----------------------------------------------------------
  logic mute_reg;     // buzzer silenced
  logic sound_prev;   // sounding alarm last cycle
  logic new_alarm;    // sounding alarm just arose
  logic [4:0] src;    // source by function code
  assign new_alarm = (crit_alarm || local_alarm) && !sound_prev;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mute_reg   <= 1'b0;
      sound_prev <= 1'b0;
    end
    else
    begin
      sound_prev <= crit_alarm || local_alarm;
      if (new_alarm)
        mute_reg <= 1'b0;
      else if (mute_req)
        mute_reg <= 1'b1;
    end
  end
  assign src = {(crit_alarm || local_alarm) && !mute_reg,
                power_fault, noncrit_alarm || local_alarm,
                crit_alarm, 1'b0};

  // ----------------------------------------------------------
  // second tick and channels
  // ----------------------------------------------------------
  logic [31:0] div_cnt;   // cycle divider
  logic        sec_tick;  // one pulse per second
  assign sec_tick = (div_cnt == 32'(TICK_CYCLES - 1));
  always_ff @(posedge aclk)
  begin
    if (!aresetn || sec_tick)
      div_cnt <= '0;
    else
      div_cnt <= div_cnt + 32'h1;
  end

  for (genvar c = 0; c < `N_CHANS; c++)
  begin : g_chan
    relay_channel u_chan (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .sec_tick  (sec_tick),
      .cfg_bits  (chan_reg[c * 5]),
      .sp1       (chan_reg[c * 5 + 1]),
      .sp2       (chan_reg[c * 5 + 2]),
      .dly1      (chan_reg[c * 5 + 3]),
      .dly2      (chan_reg[c * 5 + 4]),
      .level_pct (7'(level_reg * `PCT_PER_STEP)),
      .src_vec   (src),
      .relay_out (chan_q[c])
    );
  end
  assign relay_out = {chan_q[6], chan_q[4:0]};
  assign oc_oe     = chan_q[5];
  assign oc_out    = 1'b0;

  // ----------------------------------------------------------
  // checks
  // ----------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_bvalid_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  chk_rdata_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed before taken");
  chk_seg_probe: assert property (
    !analog_mode && $past(!analog_mode) |-> seg_reg == $past(probe_s))
    else $error("segment does not mirror probe");
  chk_seg_thermo: assert property (
    analog_mode |=> (seg_reg & (seg_reg + 10'h001)) == 10'h000)
    else $error("analogue bar not contiguous");
  chk_level_range: assert property (level_reg <= `LEVEL_MAX)
    else $error("level step beyond ten");
  chk_high_floor: assert property (
    !analog_mode && ctl_reg[`CTL_HIGHEN_BIT] && hidx < `LEVEL_MAX
    && probe_s[hidx] && (|(probe_s & ((10'h001 << hidx) - 10'h001)))
    |=> level_reg > $past(hidx) || !$stable(ctl_reg))
    else $error("high level override missing");
  chk_gap_flag: assert property (
    ##1 fault_reg == $past(ctl_reg[`CTL_FAULTEN_BIT] && !analog_mode && gap))
    else $error("probe gap flag wrong");
  chk_mute_buzz: assert property (
    mute_req && !new_alarm |=> !src[4])
    else $error("buzzer sounds after mute");
  chk_new_unmute: assert property (new_alarm |=> !mute_reg)
    else $error("new alarm stays muted");
  cov_write: cover property (do_write ##1 s_axi_bvalid);
  cov_full_bar: cover property (analog_mode && seg_reg == 10'h3ff);
  cov_gap: cover property (fault_reg);
endmodule
`default_nettype wire

// ---- design/tank_pkg.sv ----
`default_nettype none
package tank_pkg;
  // channel function codes
  typedef enum logic [2:0] {
    FN_LEVEL   = 3'h0,
    FN_CRIT    = 3'h1,
    FN_NONCRIT = 3'h2,
    FN_POWER   = 3'h3,
    FN_BUZZER  = 3'h4
  } func_e;
  // one channel parameter word
  typedef logic [15:0] param_t;
endpackage
`default_nettype wire
